// [core/bus_wait_pkg.sv]
package bus_wait_pkg;
	// ==========================================
	// Register map (printed offsets are indices)
	// ==========================================
	localparam logic [29:0] IDX_BUS_SPACE = 30'h05FFFFA0; // Bus space control
	localparam logic [29:0] IDX_RW_WAIT = 30'h05FFFFA2; // Read/write wait control
	localparam logic [29:0] IDX_DMA_WAIT = 30'h05FFFFA4; // DMA wait control
	localparam logic [29:0] IDX_LONG_WAIT = 30'h05FFFFA6; // Long wait control
	localparam logic [29:0] IDX_REFRESH_WAIT = 30'h05FFFFAC; // Refresh wait control

	// ==========================================
	// Field positions
	// ==========================================
	localparam int BIT_DRAM = 15; // area1_dram_select
	localparam int BIT_MUXIO = 14; // area6_mux_io_select
	localparam int BIT_OVERLAP = 13; // Overlap of internal and external access
	localparam int BIT_DUTY = 12; // read_strobe_duty
	localparam int BIT_BSTYLE = 11; // byte_strobe_style
	localparam int BIT_WW = 1; // dram_write_wait_bit
	localparam int POS_RW = 8; // read_wait_sample_bits low end
	localparam int POS_DRW = 8; // dma_read_wait_bits low end
	localparam int POS_LW02 = 13; // area02 long wait field low end
	localparam int POS_LW6 = 11; // Area 6 long wait field low end

	// ==========================================
	// Values after reset
	// ==========================================
	localparam logic [4:0] RST_BUS_SPACE = 5'h00; // Bits 15..11
	localparam logic [7:0] RST_RW_BITS = 8'hFF; // Sample WAIT on reads
	localparam logic RST_WW = 1'b1; // Long pitch DRAM writes
	localparam logic [15:0] RST_DMA_WAIT = 16'hFFFF; // Sample WAIT on DMA
	localparam logic [4:0] RST_LONG_WAIT = 5'h1F; // Pull-up on, four-cycle long waits
	localparam logic [1:0] RST_REFRESH = 2'h0; // One refresh wait

	// ==========================================
	// Wait counts
	// ==========================================
	localparam logic [2:0] WAITS_NONE = 3'h0; // Fixed single cycle
	localparam logic [2:0] WAITS_LONG_PITCH = 3'h2; // Two waits plus WAIT
	localparam logic [2:0] WAITS_MUX_IO = 3'h4; // Four waits plus WAIT
	localparam logic [2:0] WAITS_ONE = 3'h1; // Offset of 2-bit wait fields

	// Kind of external access
	typedef enum logic [2:0] {
		ACC_CPU_RD,
		ACC_CPU_WR,
		ACC_DMA_RD,
		ACC_DMA_WR,
		ACC_REFRESH
	} acc_kind_t;

	// Access request carried as one word
	typedef struct packed {
		acc_kind_t kind;
		logic [2:0] area;
	} acc_req_t;

	// Wait plan for one access
	typedef struct packed {
		logic [2:0] waits;
		logic sample;
	} timing_t;

	// Static bus configuration to the strobe logic
	typedef struct packed {
		logic area1_dram_select;
		logic area6_mux_io_select;
		logic overlap_en;
		logic read_strobe_duty;
		logic byte_strobe_style;
	} bus_cfg_t;
endpackage

// [core/bus_wait_ctrl.sv]
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
// What this block does
// R1: Bit 15 set makes area 1 DRAM
// R2: Bit 14 set makes area 6 multiplexed I/O
// R3: Bit 13 clear forbids concurrent internal access after the first access cycle
// R4: Bit 12 picks 50% or 35% strobe duty
// R5: Bit 11 picks write-strobe or byte-strobe style
// R6: Unsampled CPU reads: fixed or long wait
// R7: Sampled reads wait on WAIT pin
// R8: DRAM write bit clear gives short pitch
// R9: DRAM write bit set gives two plus WAIT
// R10: Software clears write bit only for DRAM
// R11: Refresh ignores WAIT, uses refresh field
// R12: Unsampled DMA access: fixed or long wait
// R13: Sampled DMA access: two plus WAIT, long wait plus WAIT in areas 0, 2 and 6
// R14: DMA to multiplexed I/O: four plus WAIT
// R15: Two-bit long wait field, 1 to 4
// R16: Bus space control resets to zero
module bus_wait_ctrl
	import bus_wait_pkg::*;
(
	input wire logic clock_i, // System clock, 20 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic [31:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [3:0] avs_byteenable_i, // Byte lanes
	input wire logic [31:0] avs_writedata_i, // Write data
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Stall the master
	input wire logic acc_start_i, // Start an external access
	input wire acc_req_t acc_req_i, // Kind and area of the access
	input wire logic wait_n_i, // WAIT pin, active low
	input wire logic internal_req_i, // Internal access wants to run
	output logic internal_grant_o, // Internal access may run
	output logic acc_busy_o, // External access in progress
	output logic acc_done_o, // First cycle after the access, pulse
	output bus_cfg_t bus_cfg_o // Space and strobe configuration
);
	// ==========================================
	// Types and storage
	// ==========================================
	typedef enum logic [1:0] {ST_IDLE, ST_COUNT} acc_state_t;

	logic waitreq_r; // Registered waitrequest
	logic [31:0] rdata_r; // Registered read data
	logic [4:0] bus_space_r; // Bits 15..11 of bus space control
	logic [7:0] rw_bits_r; // read_wait_sample_bits, index is area
	logic ww_r; // dram_write_wait_bit
	logic [15:0] dma_wait_r; // DMA read bits high, write bits low
	logic [4:0] long_wait_r; // Pull-up and both long wait fields
	logic [1:0] refresh_wait_r; // refresh_wait_hi and refresh_wait_lo
	acc_state_t state_r; // Access engine state
	logic [2:0] cnt_r; // Waits still to go
	logic sample_r; // WAIT is sampled on this access
	logic done_r; // Done pulse
	logic grant_r; // Internal grant
	logic busy_r; // Engine busy, kept in a flop so the pin has no decode glitch

	// ==========================================
	// Address decode
	// ==========================================
	wire logic [29:0] idx = avs_address_i[31:2]; // Word index
	wire logic hit_bus = (idx == IDX_BUS_SPACE); // Bus space control
	wire logic hit_rw = (idx == IDX_RW_WAIT); // Read/write wait
	wire logic hit_dma = (idx == IDX_DMA_WAIT); // DMA wait
	wire logic hit_long = (idx == IDX_LONG_WAIT); // Long wait
	wire logic hit_ref = (idx == IDX_REFRESH_WAIT); // Refresh wait
	wire logic wr_go = avs_write_i && !waitreq_r; // Write takes effect
	wire logic rd_go = avs_read_i && waitreq_r; // Read data captured
	wire logic [15:0] wd = avs_writedata_i[15:0]; // Low half only
	wire logic be_lo = avs_byteenable_i[0]; // Lane 7..0
	wire logic be_hi = avs_byteenable_i[1]; // Lane 15..8

	// Read value of the addressed register, unmapped reads zero
	logic [15:0] rd_val;
	always_comb begin
		if (hit_bus) begin
			rd_val = {bus_space_r, 11'h000};
		end else if (hit_rw) begin
			// Reserved low bits read as one
			rd_val = {rw_bits_r, 6'h3F, ww_r, 1'h1};
		end else if (hit_dma) begin
			rd_val = dma_wait_r;
		end else if (hit_long) begin
			rd_val = {long_wait_r, 11'h000};
		end else if (hit_ref) begin
			rd_val = {14'h0000, refresh_wait_r};
		end else begin
			rd_val = 16'h0000;
		end
	end

	// ==========================================
	// Wait plan
	// ==========================================
	// One function so every kind of access is planned in one place
	function automatic timing_t plan(input acc_req_t q, input logic [4:0] bs, input logic [7:0] rw,
		input logic ww, input logic [15:0] dw, input logic [4:0] lw, input logic [1:0] rf);
		timing_t t;
		logic bit_sel;
		logic long_area;
		logic [1:0] lfield;
		t.waits = WAITS_NONE;
		t.sample = 1'b0;
		long_area = (q.area == 3'h0) || (q.area == 3'h2) || (q.area == 3'h6);
		// Area 6 has its own long wait field
		lfield = (q.area == 3'h6) ? lw[POS_LW6-POS_LW6+:2] : lw[POS_LW02-POS_LW6+:2];
		case (q.kind)
			ACC_DMA_RD: bit_sel = dw[POS_DRW + 32'(q.area)];
			ACC_DMA_WR: bit_sel = dw[q.area];
			ACC_CPU_RD: bit_sel = rw[q.area];
			default: bit_sel = 1'b1;
		endcase
		if (q.kind == ACC_REFRESH) begin
			// WAIT ignored, waits from the refresh field
			t.waits = {1'b0, rf} + WAITS_ONE; // R11
		end else if ((q.area == 3'h6) && bs[BIT_MUXIO-BIT_BSTYLE]) begin
			// Multiplexed I/O
			t.waits = WAITS_MUX_IO; // R2 R14
			t.sample = 1'b1; // R14
		end else if ((q.area == 3'h1) && bs[BIT_DRAM-BIT_BSTYLE]) begin
			// DRAM column address cycle
			if (q.kind == ACC_CPU_WR) begin
				t.waits = ww ? WAITS_LONG_PITCH : WAITS_NONE; // R1 R8 R9
				t.sample = ww; // R8 R9
			end else begin
				t.waits = bit_sel ? WAITS_LONG_PITCH : WAITS_NONE; // R13
				t.sample = bit_sel; // R7 R12 R13
			end
		end else if ((q.area == 3'h1) && (q.kind == ACC_CPU_WR)) begin
			// External area 1 keeps long pitch whatever the write bit holds
			t.waits = WAITS_LONG_PITCH; // R9 R10
			t.sample = 1'b1; // R9
		end else if (long_area) begin
			// Long wait, extended by WAIT only when sampled
			t.waits = {1'b0, lfield} + WAITS_ONE; // R6 R12 R15
			t.sample = bit_sel; // R7 R13
		end else begin
			t.waits = bit_sel ? WAITS_LONG_PITCH : WAITS_NONE; // R6 R12 R13
			t.sample = bit_sel; // R7 R13
		end
		return t;
	endfunction

	wire timing_t cur_plan = plan(acc_req_i, bus_space_r, rw_bits_r, ww_r, dma_wait_r, long_wait_r,
		refresh_wait_r); // Plan for the offered access
	wire logic start_go = acc_start_i && (state_r == ST_IDLE); // Access accepted
	wire logic last_wait = (state_r == ST_COUNT) && (cnt_r == 3'h0); // Final planned cycle
	wire logic hold = sample_r && !wait_n_i; // WAIT stretches the access
	wire logic busy_now = (state_r != ST_IDLE); // External access running

	// ==========================================
	// Avalon slave
	// ==========================================
	// One stall cycle on every access keeps the decode off the read path
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			waitreq_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			waitreq_r <= !((avs_read_i || avs_write_i) && waitreq_r);
			if (rd_go) begin
				rdata_r <= {16'h0000, rd_val};
			end
		end
	end

	// Bus space control, all bits clear after reset
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			bus_space_r <= RST_BUS_SPACE; // R16
		end else if (wr_go && hit_bus && be_hi) begin
			bus_space_r <= wd[15:11]; // R1 R2 R3 R4 R5
		end
	end

	// Read/write wait control
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rw_bits_r <= RST_RW_BITS;
			ww_r <= RST_WW;
		end else if (wr_go && hit_rw) begin
			if (be_hi) begin
				rw_bits_r <= wd[POS_RW+:8];
			end
			if (be_lo) begin
				ww_r <= wd[BIT_WW];
			end
		end
	end

	// DMA, long and refresh wait control
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			dma_wait_r <= RST_DMA_WAIT;
			long_wait_r <= RST_LONG_WAIT;
			refresh_wait_r <= RST_REFRESH;
		end else if (wr_go) begin
			if (hit_dma && be_hi) begin
				dma_wait_r[15:8] <= wd[15:8];
			end
			if (hit_dma && be_lo) begin
				dma_wait_r[7:0] <= wd[7:0];
			end
			if (hit_long && be_hi) begin
				long_wait_r <= wd[15:11]; // R15
			end
			if (hit_ref && be_lo) begin
				refresh_wait_r <= wd[1:0]; // R11
			end
		end
	end

	// ==========================================
	// Access engine
	// ==========================================
	// WAIT is looked at only in the final planned cycle, so it cannot shorten an access
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
			sample_r <= 1'b0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (start_go) begin
						state_r <= ST_COUNT;
						busy_r <= 1'b1;
						cnt_r <= cur_plan.waits;
						sample_r <= cur_plan.sample;
					end
				end
				ST_COUNT: begin
					if (!last_wait) begin
						cnt_r <= cnt_r - 3'h1;
					end else if (!hold) begin
						// Unsampled accesses finish regardless of the pin
						state_r <= ST_IDLE; // R6 R12
						busy_r <= 1'b0;
						done_r <= 1'b1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	// Internal accesses wait for the external one from its second cycle on, unless overlap is on
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			grant_r <= 1'b0;
		end else begin
			grant_r <= internal_req_i && (!busy_now || bus_space_r[BIT_OVERLAP-BIT_BSTYLE]); // R3
		end
	end

	// ==========================================
	// Outputs
	// ==========================================
	assign avs_waitrequest_o = waitreq_r;
	assign avs_readdata_o = rdata_r;
	assign internal_grant_o = grant_r;
	assign acc_done_o = done_r;
	assign acc_busy_o = busy_r;
	assign bus_cfg_o = bus_space_r; // R4 R5

	// ==========================================
	// Checks
	// ==========================================
	a_bus_answer: assert property (@(posedge clock_i) disable iff (rst_i)
		(avs_read_i || avs_write_i) && waitreq_r |=> !waitreq_r)
		else $error("waitrequest not released after one stall");

	a_space_write: assert property (@(posedge clock_i) disable iff (rst_i) // R1
		wr_go && hit_bus && be_hi |=> bus_space_r == $past(wd[15:11]))
		else $error("bus space control not updated");

	a_grant_block: assert property (@(posedge clock_i) disable iff (rst_i) // R3
		internal_req_i && busy_now && !bus_space_r[BIT_OVERLAP-BIT_BSTYLE] |=> !grant_r)
		else $error("internal access granted during external access");

	a_fixed_one: assert property (@(posedge clock_i) disable iff (rst_i) // R6
		start_go && acc_req_i.kind == ACC_CPU_RD && acc_req_i.area == 3'h3 && !rw_bits_r[3]
		|-> ##2 done_r)
		else $error("unsampled read not one cycle");

	a_long_wait: assert property (@(posedge clock_i) disable iff (rst_i) // R15
		start_go && acc_req_i.kind == ACC_CPU_RD && acc_req_i.area == 3'h0 && !rw_bits_r[0]
		&& long_wait_r[3:2] == 2'h3 |-> ##1 !done_r [*5] ##1 done_r)
		else $error("four-cycle long wait wrong");

	a_dram_short: assert property (@(posedge clock_i) disable iff (rst_i) // R8
		start_go && acc_req_i.kind == ACC_CPU_WR && acc_req_i.area == 3'h1
		&& bus_space_r[BIT_DRAM-BIT_BSTYLE] && !ww_r |-> ##2 done_r)
		else $error("short pitch write not one cycle");

	a_refresh_wait: assert property (@(posedge clock_i) disable iff (rst_i) // R11
		start_go && acc_req_i.kind == ACC_REFRESH && refresh_wait_r == 2'h0
		|-> ##1 !done_r ##1 !done_r ##1 done_r)
		else $error("refresh wait not from field");

	a_mux_io: assert property (@(posedge clock_i) disable iff (rst_i) // R14
		start_go && acc_req_i.kind == ACC_DMA_RD && acc_req_i.area == 3'h6
		&& bus_space_r[BIT_MUXIO-BIT_BSTYLE] |-> ##1 !done_r [*5])
		else $error("multiplexed I/O access shorter than four waits");

	a_wait_hold: assert property (@(posedge clock_i) disable iff (rst_i) // R7
		last_wait && sample_r && !wait_n_i |=> !done_r && state_r == ST_COUNT)
		else $error("sampled WAIT did not extend access");

	a_done_cause: assert property (@(posedge clock_i) disable iff (rst_i) // R13
		done_r |-> $past(last_wait) && !$past(hold))
		else $error("done without finished wait plan");

	a_dram_long: assert property (@(posedge clock_i) disable iff (rst_i) // R9
		start_go && acc_req_i.kind == ACC_CPU_WR && acc_req_i.area == 3'h1 && ww_r
		|-> ##1 !done_r [*3])
		else $error("long pitch write shorter than two waits");

	a_dma_short: assert property (@(posedge clock_i) disable iff (rst_i) // R12
		start_go && acc_req_i.kind == ACC_DMA_RD && acc_req_i.area == 3'h3 && !dma_wait_r[11]
		|-> ##2 done_r)
		else $error("unsampled DMA read not one cycle");

	a_dma_pitch: assert property (@(posedge clock_i) disable iff (rst_i) // R13
		start_go && acc_req_i.kind == ACC_DMA_WR && acc_req_i.area == 3'h5 && dma_wait_r[5]
		|-> ##1 !done_r [*3])
		else $error("sampled DMA write shorter than two waits");

	a_grant_overlap: assert property (@(posedge clock_i) disable iff (rst_i) // R3
		internal_req_i && bus_space_r[BIT_OVERLAP-BIT_BSTYLE] |=> grant_r)
		else $error("internal access refused with overlap on");

	// The busy pin is a second copy of the state, so keep the two in step
	a_busy_flop: assert property (@(posedge clock_i) disable iff (rst_i) // R3
		busy_r == busy_now)
		else $error("busy flop out of step with engine state");
endmodule // bus_wait_ctrl

// [bench/wait_device.sv]
`timescale 1ns/1ns
// ==========================================
// Far-side device that stretches accesses with WAIT
// ==========================================
module wait_device (
	input wire logic clock_i, // System clock
	input wire logic busy_i, // External access in progress
	input wire logic [3:0] extend_i, // Cycles to hold WAIT low
	output logic wait_n_o // WAIT pin, active low
);
	logic busy_r = 1'b0; // Busy one cycle ago
	logic [3:0] hold_r = 4'h0; // Remaining stretch cycles
	// Pull-up holds the pin high whenever no stretch is pending
	assign wait_n_o = !busy_i || (hold_r == 4'h0);
	// Stretch starts one cycle after the access begins, like a slow device decoding
	always_ff @(posedge clock_i) begin
		busy_r <= busy_i;
		if (busy_i && !busy_r) begin
			hold_r <= extend_i;
		end else if (hold_r != 4'h0) begin
			hold_r <= hold_r - 4'h1;
		end
	end
endmodule // wait_device

// [bench/testbench.sv]
`timescale 1ns/1ns
module testbench;
	import bus_wait_pkg::*;
	// ==========================================
	// Stimulus and observed signals
	// ==========================================
	logic clock_i = 1'b0; // 20 MHz clock
	logic rst_i = 1'b1; // Reset, active high
	logic [31:0] avs_address_i = 32'h00000000; // Byte address
	logic avs_read_i = 1'b0; // Read request
	logic avs_write_i = 1'b0; // Write request
	logic [3:0] avs_byteenable_i = 4'hF; // Lanes
	logic [31:0] avs_writedata_i = 32'h00000000; // Write data
	logic [31:0] avs_readdata_o; // Read data
	logic avs_waitrequest_o; // Stall
	logic acc_start_i = 1'b0; // Access start
	acc_req_t acc_req_i = '0; // Kind and area
	logic wait_n_i; // WAIT from far side
	logic internal_req_i = 1'b0; // Internal request
	logic internal_grant_o; // Internal grant
	logic acc_busy_o; // Engine busy
	logic acc_done_o; // Access done pulse
	bus_cfg_t bus_cfg_o; // Bus configuration
	logic [3:0] ext = 4'h0; // Stretch asked of the far side
	logic g_mid; // Grant seen mid-access
	logic b_first; // Busy seen in the first access cycle
	logic [31:0] rd; // Last read value
	int n_mismatch = 0; // Mismatches
	int samples_checked = 0; // Comparisons
	always #25 clock_i = ~clock_i;
	bus_wait_ctrl uut (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .acc_start_i(acc_start_i), .acc_req_i(acc_req_i),
		.wait_n_i(wait_n_i), .internal_req_i(internal_req_i), .internal_grant_o(internal_grant_o),
		.acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o), .bus_cfg_o(bus_cfg_o));
	wait_device far (.clock_i(clock_i), .busy_i(acc_busy_o), .extend_i(ext), .wait_n_o(wait_n_i));
	// ==========================================
	// Shared tasks
	// ==========================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Avalon cycle: held until waitrequest is sampled low, with no cycle limit
	task automatic bus(input logic wr, input logic [29:0] idx, input logic [15:0] d);
		int n;
		@(posedge clock_i);
		avs_address_i <= {idx, 2'b00};
		avs_writedata_i <= {16'h0000, d};
		avs_write_i <= wr;
		avs_read_i <= !wr;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		// One stall cycle, then the answer
		chk(n, 32'd2);
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic rchk(input logic [29:0] idx, input logic [15:0] exp);
		bus(1'b0, idx, 16'h0000);
		chk(rd, {16'h0000, exp});
	endtask
	// One access; counts edges from the taking edge to the done cycle
	task automatic acc(input acc_kind_t k, input logic [2:0] a, input logic [3:0] x, input int exp);
		int n;
		@(posedge clock_i);
		ext <= x;
		acc_req_i <= '{kind: k, area: a};
		acc_start_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			acc_start_i <= 1'b0;
			n++;
			#1;
			if (n == 1) b_first = acc_busy_o;
			if (n == 3) g_mid = internal_grant_o;
		end while (acc_done_o !== 1'b1 && n < 40);
		chk(n, exp);
		chk({b_first, acc_busy_o}, 32'h2);
	endtask
	task automatic print_verdict;
		$display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ==========================================
	// Scenarios
	// ==========================================
	task automatic t_reset;
		chk(bus_cfg_o, 32'h0);
		rchk(IDX_BUS_SPACE, 16'h0000);
		rchk(IDX_RW_WAIT, 16'hFFFF);
		rchk(IDX_DMA_WAIT, 16'hFFFF);
		rchk(IDX_LONG_WAIT, 16'hF800);
		rchk(IDX_REFRESH_WAIT, 16'h0000);
		rchk(30'h05FFFFAE, 16'h0000);
	endtask
	task automatic t_cfg;
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, IDX_BUS_SPACE, 16'h0800 << i);
			// Write lands at the edge the task returns on, so look once it has settled
			@(negedge clock_i);
			chk(bus_cfg_o, 32'h1 << i);
			rchk(IDX_BUS_SPACE, 16'h0800 << i);
		end
		// Unmapped write must not disturb the space register
		bus(1'b1, 30'h05FFFFAE, 16'h0000);
		rchk(IDX_BUS_SPACE, 16'h8000);
		bus(1'b1, IDX_BUS_SPACE, 16'h0000);
	endtask
	task automatic t_overlap;
		internal_req_i <= 1'b1;
		acc(ACC_CPU_RD, 3'h3, 4'h0, 4);
		chk(g_mid, 1'b0);
		bus(1'b1, IDX_BUS_SPACE, 16'h2000);
		acc(ACC_CPU_RD, 3'h3, 4'h0, 4);
		chk(g_mid, 1'b1);
		bus(1'b1, IDX_BUS_SPACE, 16'h0000);
		internal_req_i <= 1'b0;
	endtask
	task automatic t_cpu_read;
		acc(ACC_CPU_RD, 3'h3, 4'h4, 7);
		acc(ACC_CPU_RD, 3'h0, 4'h0, 6);
		bus(1'b1, IDX_LONG_WAIT, 16'hB800);
		acc(ACC_CPU_RD, 3'h0, 4'h0, 4);
		acc(ACC_CPU_RD, 3'h6, 4'h0, 6);
		bus(1'b1, IDX_RW_WAIT, 16'h00FF);
		acc(ACC_CPU_RD, 3'h3, 4'h4, 2);
		acc(ACC_CPU_RD, 3'h2, 4'h4, 4);
		bus(1'b1, IDX_LONG_WAIT, 16'hF800);
		acc(ACC_CPU_RD, 3'h0, 4'h4, 6);
		bus(1'b1, IDX_RW_WAIT, 16'hFFFF);
	endtask
	// Write bit is cleared only while area 1 is DRAM, and set again before leaving
	task automatic t_dram;
		acc(ACC_CPU_WR, 3'h1, 4'h3, 6);
		bus(1'b1, IDX_BUS_SPACE, 16'h8000);
		acc(ACC_CPU_WR, 3'h1, 4'h3, 6);
		bus(1'b1, IDX_RW_WAIT, 16'hFFFD);
		acc(ACC_CPU_WR, 3'h1, 4'h3, 2);
		bus(1'b1, IDX_RW_WAIT, 16'hFFFF);
		bus(1'b1, IDX_BUS_SPACE, 16'h0000);
	endtask
	task automatic t_dma;
		acc(ACC_DMA_WR, 3'h5, 4'h3, 6);
		acc(ACC_DMA_RD, 3'h7, 4'h2, 5);
		bus(1'b1, IDX_DMA_WAIT, 16'h0000);
		acc(ACC_DMA_RD, 3'h3, 4'h4, 2);
		acc(ACC_DMA_WR, 3'h0, 4'h4, 6);
		bus(1'b1, IDX_BUS_SPACE, 16'h4000);
		acc(ACC_DMA_RD, 3'h6, 4'h5, 8);
		bus(1'b1, IDX_BUS_SPACE, 16'h0000);
		bus(1'b1, IDX_DMA_WAIT, 16'hFFFF);
	endtask
	task automatic t_refresh;
		bus(1'b1, IDX_REFRESH_WAIT, 16'h0002);
		acc(ACC_REFRESH, 3'h0, 4'h6, 5);
		bus(1'b1, IDX_REFRESH_WAIT, 16'h0000);
		acc(ACC_REFRESH, 3'h0, 4'h6, 3);
	endtask
	// ==========================================
	// Main sequence and watchdog
	// ==========================================
	initial begin
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		t_reset();
		t_cfg();
		t_overlap();
		t_cpu_read();
		t_dram();
		t_dma();
		t_refresh();
		repeat (2) @(posedge clock_i);
		print_verdict();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#(50 * 5000);
		n_mismatch++;
		print_verdict();
	end
endmodule // testbench
